/* fct_cfg.svh */
// offsets, field positions, reset values and timing counts of the fixed-cycle timer
// assumes a 100 MHz system clock and a 32768 Hz oscillator derived from it
`ifndef FCT_CFG_SVH
`define FCT_CFG_SVH

`define FCT_ADDR_SETUP    4'hc
`define FCT_ADDR_COUNT    4'hd
`define FCT_ADDR_CTRL     4'he

`define FCT_RUN_BIT       7
`define FCT_SRC_HI_BIT    5
`define FCT_SRC_LO_BIT    4
`define FCT_MODE_BIT      4
`define FCT_ALARM_BIT     3
`define FCT_FLAG_BIT      2
`define FCT_AIE_BIT       1
`define FCT_IE_BIT        0

`define FCT_RST_PRESET    8'h00
`define FCT_RST_SRC       2'h0

`define FCT_SRC_4096      2'h0
`define FCT_SRC_64        2'h1
`define FCT_SRC_1         2'h2
`define FCT_SRC_MIN       2'h3

`define FCT_CLK_HZ        100000000
`define FCT_CLK_NS        10
`define FCT_OSC_HZ        32768
`define FCT_OSC_DIV_CYC   ((`FCT_CLK_HZ + `FCT_OSC_HZ / 2) / `FCT_OSC_HZ)
`define FCT_PRE_4096_MASK 15'h0007
`define FCT_PRE_64_MASK   15'h01ff
`define FCT_PRE_1_MASK    15'h7fff
`define FCT_SEC_LAST      6'h3b

`define FCT_RTN_FAST_NS   122000
`define FCT_RTN_SLOW_NS   7813000
`define FCT_RTN_FAST_CYC  (`FCT_RTN_FAST_NS / `FCT_CLK_NS)
`define FCT_RTN_SLOW_CYC  (`FCT_RTN_SLOW_NS / `FCT_CLK_NS)

`endif

/* fct_pkg.sv */
// types of the fixed-cycle timer
// assumes nothing beyond a SystemVerilog compiler
package fct_pkg;
  typedef enum logic [3:0] {
    FCT_IDLE = 4'b0001,
    FCT_WAIT = 4'b0010,
    FCT_RUN  = 4'b0100,
    FCT_DONE = 4'b1000
  } fct_state_t;
endpackage

/* fct_timer.sv */
// fixed-cycle interrupt timer with register port and open-drain interrupt
// assumes link_clk is the serial port clock, asynchronous to clk
//
// Contract
// - run enable 0 halts; 0-to-1 restarts from preset
// - event sets flag; drives irq if enabled
// - writing 0 clears flag; 1 ignored
// - flag sticky; level stop keeps irq
// - irq enable 0 blocks or releases output
// - countdown starts at serial clock rising edge
// - period is preset times source period
// - first interval up to one tick short
// - event at 01h to 00h; level ends
// - level mode: enable toggles output while flagged
// - level mode: clearing flag releases output
// - repeat mode reloads preset after event
// - repeat mode: output low for return time
// - repeat mode: stop releases output immediately
// - repeat mode: flag clear keeps output low
// - repeat mode: enable fall releases output
// - two-bit source select picks countdown clock
// - return time 122 us or 7.813 ms
// - mode bit: 0 level, 1 repeat
`timescale 1ns/1ps
`include "fct_cfg.svh"

module fct_timer #(
  parameter int unsigned OSC_DIV_CYC  = `FCT_OSC_DIV_CYC,
  parameter int unsigned RTN_FAST_CYC = `FCT_RTN_FAST_CYC,
  parameter int unsigned RTN_SLOW_CYC = `FCT_RTN_SLOW_CYC
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       link_clk,
  output logic            timer_irq_out_n,
  output logic            timer_irq_oe
);
  import fct_pkg::*;

  localparam logic [11:0] OSC_LAST  = 12'(OSC_DIV_CYC - 1);
  localparam logic [19:0] RTN_FAST  = 20'(RTN_FAST_CYC - 1);
  localparam logic [19:0] RTN_SLOW  = 20'(RTN_SLOW_CYC - 1);

  fct_state_t  st_r;
  logic        timer_run_enable;
  logic        source_select_hi;
  logic        source_select_lo;
  logic        repeat_mode_select;
  logic        timer_irq_enable;
  logic        timer_event_flag;
  logic [7:0]  preset_r;
  logic [7:0]  cnt_r;
  logic [11:0] osc_div_r;
  logic [14:0] osc_cnt_r;
  logic [5:0]  sec_r;
  logic        osc_tick;
  logic        src_tick;
  logic [1:0]  src_sel;
  logic [2:0]  link_sync_r;
  logic        link_rise;
  logic        rep_low_r;
  logic [19:0] rtn_cnt_r;
  logic        wr_setup;
  logic        wr_ctrl;
  logic        start_req;
  logic        stop_req;
  logic        clr_req;
  logic        ie_fall;
  logic        evt;
  logic        flag_nxt;
  logic        ie_nxt;
  logic        rep_low_nxt;
  logic        irq_oe_r;
  logic        irq_n_r;
  logic [7:0]  rdata_r;

  assign src_sel   = {source_select_hi, source_select_lo};
  assign wr_setup  = wr && (addr == `FCT_ADDR_SETUP);
  assign wr_ctrl   = wr && (addr == `FCT_ADDR_CTRL);
  assign start_req = wr_setup && wdata[`FCT_RUN_BIT] && !timer_run_enable;
  assign stop_req  = wr_setup && !wdata[`FCT_RUN_BIT];
  assign clr_req   = wr_ctrl && !wdata[`FCT_FLAG_BIT];
  assign ie_fall   = wr_ctrl && !wdata[`FCT_IE_BIT] && timer_irq_enable;
  assign link_rise = link_sync_r[1] && !link_sync_r[2];
  assign evt       = (st_r == FCT_RUN) && src_tick && (cnt_r == 8'h01);

  // register file
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_run_enable   <= 1'b0;
      source_select_hi   <= 1'b0;
      source_select_lo   <= 1'b0;
      preset_r           <= `FCT_RST_PRESET;
      repeat_mode_select <= 1'b0;
      timer_irq_enable   <= 1'b0;
    end else if (wr_setup) begin
      timer_run_enable <= wdata[`FCT_RUN_BIT];
      source_select_hi <= wdata[`FCT_SRC_HI_BIT];
      source_select_lo <= wdata[`FCT_SRC_LO_BIT];
    end else if (wr && addr == `FCT_ADDR_COUNT) begin
      preset_r <= wdata;
    end else if (wr_ctrl) begin
      repeat_mode_select <= wdata[`FCT_MODE_BIT];
      timer_irq_enable   <= wdata[`FCT_IE_BIT];
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 8'h00;
    end else if (!rd) begin
      rdata_r <= 8'h00;
    end else begin
      case (addr)
        `FCT_ADDR_SETUP: rdata_r <= {timer_run_enable, 1'b0, src_sel, 4'h0};
        `FCT_ADDR_COUNT: rdata_r <= preset_r;
        `FCT_ADDR_CTRL:  rdata_r <= {3'h0, repeat_mode_select, 1'b0,
                                     timer_event_flag, 1'b0, timer_irq_enable};
        default:         rdata_r <= 8'h00;
      endcase
    end
  end

  // free-running oscillator; not realigned on start, so the first interval can be short
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_div_r <= 12'h000;
      osc_cnt_r <= 15'h0000;
      sec_r     <= 6'h00;
    end else if (osc_div_r == OSC_LAST) begin
      osc_div_r <= 12'h000;
      osc_cnt_r <= osc_cnt_r + 15'h0001;
      if (osc_cnt_r == `FCT_PRE_1_MASK) begin
        sec_r <= (sec_r == `FCT_SEC_LAST) ? 6'h00 : sec_r + 6'h01;
      end
    end else begin
      osc_div_r <= osc_div_r + 12'h001;
    end
  end

  assign osc_tick = (osc_div_r == OSC_LAST);

  always_comb begin
    case (src_sel)
      `FCT_SRC_4096: src_tick = osc_tick
                                && ((osc_cnt_r & `FCT_PRE_4096_MASK) == `FCT_PRE_4096_MASK);
      `FCT_SRC_64:   src_tick = osc_tick && ((osc_cnt_r & `FCT_PRE_64_MASK) == `FCT_PRE_64_MASK);
      `FCT_SRC_1:    src_tick = osc_tick && (osc_cnt_r == `FCT_PRE_1_MASK);
      default:       src_tick = osc_tick && (osc_cnt_r == `FCT_PRE_1_MASK)
                                && (sec_r == `FCT_SEC_LAST);
    endcase
  end

  // link clock synchroniser; stage 0 feeds stage 1 only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      link_sync_r <= 3'h0;
    end else begin
      link_sync_r <= {link_sync_r[1:0], link_clk};
    end
  end

  // countdown sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r  <= FCT_IDLE;
      cnt_r <= `FCT_RST_PRESET;
    end else begin
      case (st_r)
        FCT_IDLE: begin
          if (start_req) begin
            st_r <= FCT_WAIT;
          end
        end
        FCT_WAIT: begin
          if (stop_req) begin
            st_r <= FCT_IDLE;
          end else if (link_rise) begin
            st_r  <= FCT_RUN;
            cnt_r <= preset_r;
          end
        end
        FCT_RUN: begin
          if (stop_req) begin
            st_r <= FCT_IDLE;
          end else if (evt) begin
            if (repeat_mode_select) begin
              cnt_r <= preset_r;
            end else begin
              cnt_r <= 8'h00;
              st_r  <= FCT_DONE;
            end
          end else if (src_tick && cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        FCT_DONE: begin
          if (stop_req) begin
            st_r <= FCT_IDLE;
          end
        end
        default: st_r <= FCT_IDLE;
      endcase
    end
  end

  // flag: event wins over a same-cycle clear
  always_comb begin
    flag_nxt = timer_event_flag;
    if (evt) begin
      flag_nxt = 1'b1;
    end else if (clr_req) begin
      flag_nxt = 1'b0;
    end
    ie_nxt = wr_ctrl ? wdata[`FCT_IE_BIT] : timer_irq_enable;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      timer_event_flag <= 1'b0;
    end else begin
      timer_event_flag <= flag_nxt;
    end
  end

  // repeat-mode pulse with auto return
  always_comb begin
    rep_low_nxt = rep_low_r;
    if (!repeat_mode_select || stop_req || ie_fall) begin
      rep_low_nxt = 1'b0;
    end else if (evt && timer_irq_enable) begin
      rep_low_nxt = 1'b1;
    end else if (rep_low_r && rtn_cnt_r == 20'h00000) begin
      rep_low_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rep_low_r <= 1'b0;
      rtn_cnt_r <= 20'h00000;
    end else begin
      rep_low_r <= rep_low_nxt;
      if (evt) begin
        rtn_cnt_r <= (src_sel == `FCT_SRC_4096) ? RTN_FAST : RTN_SLOW;
      end else if (rtn_cnt_r != 20'h00000) begin
        rtn_cnt_r <= rtn_cnt_r - 20'h00001;
      end
    end
  end

  // open-drain pin: only ever pulls low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_oe_r <= 1'b0;
      irq_n_r  <= 1'b0;
    end else begin
      irq_n_r  <= 1'b0;
      irq_oe_r <= repeat_mode_select ? rep_low_nxt
                                     : (flag_nxt && ie_nxt);
    end
  end

  assign rdata           = rdata_r;
  assign timer_irq_out_n = irq_n_r;
  assign timer_irq_oe    = irq_oe_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_flag_set: assert property (evt |=> timer_event_flag)
    else $error("event did not set flag");
  chk_flag_clr: assert property (clr_req && !evt |=> !timer_event_flag)
    else $error("flag clear lost");
  chk_flag_w1: assert property (wr_ctrl && wdata[`FCT_FLAG_BIT] && !timer_event_flag
    && !evt |=> !timer_event_flag)
    else $error("writing one set flag");
  chk_flag_hold: assert property (timer_event_flag && !clr_req |=> timer_event_flag)
    else $error("flag dropped without clear");
  chk_clr_race: assert property (evt && clr_req |=> timer_event_flag)
    else $error("clear beat event");
  chk_start_load: assert property (st_r == FCT_WAIT && link_rise && !stop_req
    |=> st_r == FCT_RUN && cnt_r == $past(preset_r))
    else $error("start did not load preset");
  chk_lvl_end: assert property (evt && !repeat_mode_select && !stop_req
    |=> st_r == FCT_DONE ##1 st_r != FCT_RUN)
    else $error("level mode kept running");
  chk_rep_reload: assert property (evt && repeat_mode_select && !stop_req
    |=> st_r == FCT_RUN && cnt_r == $past(preset_r))
    else $error("repeat mode did not reload");
  chk_lvl_release: assert property (!repeat_mode_select && !flag_nxt
    |=> !timer_irq_oe)
    else $error("level irq held without flag");
  chk_rep_stop: assert property (repeat_mode_select && (stop_req || ie_fall)
    |=> !timer_irq_oe)
    else $error("repeat irq not released");
  // a clear that also leaves repeat mode is not covered by the repeat-mode hold
  chk_rep_keep: assert property (repeat_mode_select && timer_irq_oe && clr_req
    && wdata[`FCT_MODE_BIT] && !stop_req && !ie_fall && rtn_cnt_r > 20'h00002
    |=> timer_irq_oe [*2])
    else $error("flag clear released repeat irq");

  cov_lvl_event: cover property (evt && !repeat_mode_select && timer_irq_enable);
  cov_rep_event: cover property (evt && repeat_mode_select ##1 timer_irq_oe);
  cov_rep_return: cover property (repeat_mode_select && $fell(timer_irq_oe) && !stop_req);
  cov_race: cover property (evt && clr_req);
endmodule

/* fct_host_link.sv */
// host side of the serial port, reduced to the clock it makes
// assumes the bench asks for one frame after each arming write
`timescale 1ns/1ps

module fct_host_link #(
  parameter int unsigned BITS = 1
) (
  input  wire logic frame_req,
  output logic      link_clk
);
  initial link_clk = 1'b0;

  // idles low between frames; the last rise shifts in bit 0
  always @(posedge frame_req) begin
    repeat (BITS) begin
      #62.5 link_clk = 1'b1;
      #62.5 link_clk = 1'b0;
    end
  end
endmodule

/* fixed_cycle_timer_irq_tb.sv */
// scenario testbench for the fixed-cycle timer
// assumes shortened counts: osc tick 4 clk, return times 5 and 20 clk
`timescale 1ns/1ps
`include "fct_cfg.svh"

module fixed_cycle_timer_irq_tb;
  logic       clk;
  logic       arst_n;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       link_clk;
  logic       frame_req;
  logic       irq_n;
  logic       irq_oe;
  int         num_errors;
  int         checks;
  int         n;
  logic [7:0] d;

  fct_timer #(.OSC_DIV_CYC(4), .RTN_FAST_CYC(5), .RTN_SLOW_CYC(20)) uut (
    .clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .link_clk(link_clk), .timer_irq_out_n(irq_n), .timer_irq_oe(irq_oe));
  fct_host_link host (.frame_req(frame_req), .link_clk(link_clk));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  // bounded wait; cnt equals max when the level never came
  task automatic wait_oe(input logic v, input int max, output int cnt);
    cnt = 0;
    #1;
    while (cnt < max && irq_oe !== v) begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask

  task automatic next_oe(input logic exp);
    @(posedge clk);
    #1;
    chk(8'(irq_oe), 8'(exp));
  endtask

  // arming write, then the frame whose clock starts the countdown
  task automatic arm(input logic [7:0] setup);
    wr_reg(`FCT_ADDR_SETUP, setup | 8'h80);
    frame_req <= 1'b1;
    @(posedge clk);
    frame_req <= 1'b0;
  endtask

  task automatic t_regs;
    rd_reg(`FCT_ADDR_SETUP, d);
    chk(d, 8'h00);
    rd_reg(`FCT_ADDR_CTRL, d);
    chk(d, 8'h00);
    wr_reg(`FCT_ADDR_SETUP, 8'h7f);
    rd_reg(`FCT_ADDR_SETUP, d);
    chk(d, 8'h30);
    wr_reg(`FCT_ADDR_COUNT, 8'hff);
    rd_reg(`FCT_ADDR_COUNT, d);
    chk(d, 8'hff);
    wr_reg(`FCT_ADDR_CTRL, 8'h1f);
    rd_reg(`FCT_ADDR_CTRL, d);
    chk(d, 8'h11);
    wr_reg(4'h3, 8'hff);
    rd_reg(4'h3, d);
    chk(d, 8'h00);
    chk(8'({irq_n, irq_oe}), 8'h00);
    wr_reg(`FCT_ADDR_SETUP, 8'h00);
    $display("t_regs done");
  endtask

  task automatic t_level;
    wr_reg(`FCT_ADDR_COUNT, 8'h03);
    wr_reg(`FCT_ADDR_CTRL, 8'h01);
    arm(8'h00);
    wait_oe(1'b1, 120, n);
    chk(8'(n >= 64 && n < 120), 8'h01);
    rd_reg(`FCT_ADDR_CTRL, d);
    chk(d, 8'h05);
    wr_reg(`FCT_ADDR_CTRL, 8'h04);
    next_oe(1'b0);
    wr_reg(`FCT_ADDR_CTRL, 8'h05);
    next_oe(1'b1);
    wr_reg(`FCT_ADDR_SETUP, 8'h00);
    wait_oe(1'b0, 100, n);
    chk(8'(n), 8'd100);
    rd_reg(`FCT_ADDR_CTRL, d);
    chk(d, 8'h05);
    wr_reg(`FCT_ADDR_CTRL, 8'h01);
    next_oe(1'b0);
    $display("t_level done");
  endtask

  task automatic t_repeat;
    wr_reg(`FCT_ADDR_COUNT, 8'h02);
    wr_reg(`FCT_ADDR_CTRL, 8'h11);
    arm(8'h00);
    wait_oe(1'b1, 100, n);
    chk(8'(n < 100), 8'h01);
    wait_oe(1'b0, 10, n);
    chk(8'(n), 8'd5);
    wait_oe(1'b1, 80, n);
    chk(8'(n), 8'd59);
    wr_reg(`FCT_ADDR_CTRL, 8'h11);
    next_oe(1'b1);
    rd_reg(`FCT_ADDR_CTRL, d);
    chk(d, 8'h11);
    wait_oe(1'b1, 80, n);
    wr_reg(`FCT_ADDR_CTRL, 8'h10);
    next_oe(1'b0);
    wait_oe(1'b1, 70, n);
    chk(8'(n), 8'd70);
    rd_reg(`FCT_ADDR_CTRL, d);
    chk(d, 8'h14);
    wr_reg(`FCT_ADDR_CTRL, 8'h11);
    wait_oe(1'b1, 70, n);
    chk(8'(n < 70), 8'h01);
    wr_reg(`FCT_ADDR_SETUP, 8'h00);
    next_oe(1'b0);
    wait_oe(1'b1, 100, n);
    chk(8'(n), 8'd100);
    $display("t_repeat done");
  endtask

  // 64 Hz source: one tick per 2048 clk at the shortened oscillator
  task automatic t_slow;
    wr_reg(`FCT_ADDR_COUNT, 8'h01);
    wr_reg(`FCT_ADDR_CTRL, 8'h11);
    arm(8'h10);
    wait_oe(1'b1, 2200, n);
    chk(8'(n < 2200), 8'h01);
    wait_oe(1'b0, 30, n);
    chk(8'(n), 8'd20);
    wait_oe(1'b1, 2100, n);
    chk(8'(n == 2028), 8'h01);
    wr_reg(`FCT_ADDR_SETUP, 8'h00);
    $display("t_slow done");
  endtask

  task automatic give_verdict;
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // tests need about 4100 clk
  initial begin
    #200000;
    num_errors++;
    give_verdict;
  end

  initial begin
    arst_n     = 1'b0;
    addr       = 4'h0;
    wdata      = 8'h00;
    wr         = 1'b0;
    rd         = 1'b0;
    frame_req  = 1'b0;
    num_errors = 0;
    checks     = 0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    t_regs;
    t_level;
    t_repeat;
    t_slow;
    give_verdict;
  end
endmodule
